// ### logic/dcmt_pkg.sv
// Package of constants and carrier types for the DRAM command timing block
`default_nettype none

package dcmt_pkg;

    // Clock and conversion basis
    localparam int unsigned CLK_PERIOD_PS = 5000;

    // Cycle-counted spacings
    localparam int unsigned MODE_SET_SPACING_CYC = 4;
    localparam int unsigned WSTART_LONG_CYC = 4;
    localparam int unsigned WSTART_SHORT_CYC = 2;
    localparam int unsigned TERM_HIGH_SHORT_CYC = 4;
    localparam int unsigned TERM_HIGH_LONG_CYC = 6;
    localparam int unsigned ZQCS_CYC = 64;

    // Nanosecond figures (in ps) and their rounded cycle counts
    localparam int unsigned XP_MIN_CK = 3;
    localparam int unsigned XP_MIN_PS = 6000;
    localparam int unsigned XP_NS_CYC = (XP_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned XP_CYC = (XP_NS_CYC > XP_MIN_CK) ? XP_NS_CYC : XP_MIN_CK;
    localparam int unsigned XPDLL_MIN_CK = 10;
    localparam int unsigned XPDLL_MIN_PS = 24000;
    localparam int unsigned XPDLL_NS_CYC =
        (XPDLL_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned XPDLL_CYC =
        (XPDLL_NS_CYC > XPDLL_MIN_CK) ? XPDLL_NS_CYC : XPDLL_MIN_CK;
    localparam int unsigned ASYNC_TERM_MAX_PS = 8500;
    localparam int unsigned ASYNC_TERM_FLOOR = ASYNC_TERM_MAX_PS / CLK_PERIOD_PS;
    localparam int unsigned ASYNC_TERM_CYC = (ASYNC_TERM_FLOOR > 0) ? ASYNC_TERM_FLOOR : 1;
    localparam int unsigned ROW_OP_PS = 13500;
    localparam int unsigned ROW_OP_CYC = (ROW_OP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned REFRESH_OP_PS = 160000;
    localparam int unsigned REFRESH_OP_CYC =
        (REFRESH_OP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned REFRESH_INTERVAL_PS = 7800000;
    localparam int unsigned REFRESH_INTERVAL_CYC = REFRESH_INTERVAL_PS / CLK_PERIOD_PS;
    localparam int unsigned REFRESH_POSTPONE_MAX = 9;
    localparam int unsigned REFRESH_GAP_CYC = REFRESH_POSTPONE_MAX * REFRESH_INTERVAL_CYC;

    // Termination latency is write latency less two; this offset takes one more off for indexing
    localparam logic [4:0] TERM_LAT_INDEX_OFS = 5'h03;

    // Timer bank layout
    localparam int unsigned TMR_W = 16;
    localparam int unsigned T_MRS = 0;
    localparam int unsigned T_XP = 1;
    localparam int unsigned T_XPDLL = 2;
    localparam int unsigned T_WRPD = 3;
    localparam int unsigned T_OPS = 4;
    localparam int unsigned T_ZQ = 5;
    localparam int unsigned NUM_TMR = 6;

    // Burst modes held in mode_register_zero
    localparam logic [1:0] BM_BL8_FIXED = 2'h0;
    localparam logic [1:0] BM_OTF = 2'h1;
    localparam logic [1:0] BM_BC4_FIXED = 2'h2;

    // Reset values
    localparam logic [TMR_W-1:0] TMR_RST = 16'h0000;
    localparam logic [15:0] TERM_HIST_RST = 16'h0000;
    localparam logic [31:0] WPIPE_RST = 32'h0000_0000;
    localparam logic [2:0] TERM_CNT_RST = 3'h0;

    typedef enum logic [3:0] {
        CMD_NOP = 4'h0,
        CMD_MRS = 4'h1,
        CMD_REF = 4'h2,
        CMD_ACT = 4'h3,
        CMD_PRE = 4'h4,
        CMD_RD = 4'h5,
        CMD_RDA = 4'h6,
        CMD_WR = 4'h7,
        CMD_WRA = 4'h8,
        CMD_ZQCS = 4'h9
    } dcmt_op_t;

    typedef enum logic [2:0] {
        PS_ACTIVE = 3'h1,
        PS_PENDING = 3'h2,
        PS_DOWN = 3'h4
    } dcmt_pstate_t;

    typedef struct packed {
        dcmt_op_t op;
        logic otf_bc4;
    } dcmt_cmd_t;

    typedef struct packed {
        logic [4:0] write_latency_cycles;
        logic [3:0] wr_cycles;
        logic [1:0] burst_mode;
        logic dll_frozen_pd;
    } dcmt_mode_t;

endpackage

`default_nettype wire

// ### logic/dcmt_timer.sv
// Down counter that holds off a dependent command until its count expires
`default_nettype none

module dcmt_timer
    import dcmt_pkg::*;
(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // Load request
    input wire logic load_in,
    input wire logic [TMR_W-1:0] load_val_in,
    // Status
    output logic busy_out,
    output logic last_out
);

    logic [TMR_W-1:0] count_reg;
    logic [TMR_W-1:0] count_next;

    // A load only extends, so a short spacing never cuts a long one short
    always_comb begin
        count_next = count_reg;
        if (count_reg != TMR_RST) begin
            count_next = count_reg - 16'h0001;
        end
        if (load_in && (load_val_in > count_next)) begin
            count_next = load_val_in;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_reg <= TMR_RST;
        end else begin
            count_reg <= count_next;
        end
    end

    assign busy_out = (count_reg != TMR_RST);
    assign last_out = (count_reg == 16'h0001);

endmodule

`default_nettype wire

// ### logic/dcmt_core.sv
// Device-side command timing engine of a DDR3 memory
// Operation
// - Nanosecond minimums become rounded-up cycle counts at the average period; maxima round down.
// - Auto-precharge write recovery comes from the mode_register_zero field.
// - Internal write starts write latency plus four, or plus two for fixed chop.
// - Clock enable low may arrive mid row, precharge or refresh operation; low power waits for completion.
// - Asynchronous termination delays apply in frozen-DLL precharge power down.
// - After power down, read, read-precharge and sync termination need locked DLL.
// - A short calibration completes within 64 clock cycles.
// - No maximum clock period except meeting the refresh interval.
`default_nettype none

module dcmt_core
    import dcmt_pkg::*;
#(
    parameter int unsigned REFRESH_GAP_CYCLES = REFRESH_GAP_CYC
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // Command bus as registered at each rising edge
    input wire dcmt_cmd_t cmd_in,
    input wire logic cke_in,
    input wire logic odt_in,
    // Mode register contents
    input wire dcmt_mode_t mode_in,
    // Device status
    output logic write_start_out,
    output logic low_power_out,
    output logic term_on_out,
    output logic zq_busy_out,
    output logic zq_done_out,
    output logic violation_out
);

    // Write decode, shared by several paths
    function automatic logic is_write(input dcmt_op_t op);
        is_write = (op == CMD_WR) || (op == CMD_WRA);
    endfunction

    // Commands that only a locked DLL can serve
    function automatic logic needs_locked_dll(input dcmt_op_t op, input logic odt_rise);
        needs_locked_dll = (op == CMD_RD) || (op == CMD_RDA) || odt_rise;
    endfunction

    dcmt_pstate_t state_reg;
    dcmt_pstate_t state_next;
    logic cke_prev_reg;
    logic odt_prev_reg;
    logic [15:0] term_hist_reg;
    logic [15:0] term_hist_next;
    logic term_reg;
    logic term_next;
    logic [31:0] wpipe_reg;
    logic [31:0] wpipe_next;
    logic [2:0] term_cnt_reg;
    logic [2:0] term_cnt_next;
    logic [2:0] term_need_reg;
    logic [2:0] term_need_next;
    logic [15:0] gap_cnt_reg;
    logic [15:0] gap_cnt_next;
    logic gap_armed_reg;
    logic gap_armed_next;
    logic zq_done_reg;
    logic viol_reg;
    logic viol_next;
    logic [NUM_TMR-1:0] tmr_load;
    logic [TMR_W-1:0] tmr_val [NUM_TMR];
    logic [NUM_TMR-1:0] tmr_busy;
    logic [NUM_TMR-1:0] tmr_last;
    logic cke_fall;
    logic cke_rise;
    logic pd_exit;
    logic odt_rise;
    logic odt_fall;
    logic wr_go;
    logic wr_bl8;
    logic [5:0] wdelay;
    logic [TMR_W-1:0] wr_recovery;

    // Edge and command decode
    assign cke_fall = cke_prev_reg && !cke_in;
    assign cke_rise = !cke_prev_reg && cke_in;
    assign pd_exit = cke_rise && (state_reg != PS_ACTIVE);
    assign odt_rise = odt_in && !odt_prev_reg;
    assign odt_fall = !odt_in && odt_prev_reg;
    assign wr_go = is_write(cmd_in.op);
    assign wr_bl8 = wr_go && ((mode_in.burst_mode == BM_BL8_FIXED) ||
                              ((mode_in.burst_mode == BM_OTF) && !cmd_in.otf_bc4));
    // Only a chop fixed by mode register shortens the start delay
    assign wdelay = {1'b0, mode_in.write_latency_cycles} +
                    ((mode_in.burst_mode == BM_BC4_FIXED) ? 6'(WSTART_SHORT_CYC)
                                                           : 6'(WSTART_LONG_CYC));
    // Start delay plus recovery cycles straight from the mode field, already rounded up
    assign wr_recovery = 16'(wdelay) + 16'(mode_in.wr_cycles);

    // Timer bank: one hold-off counter per parameter
    generate
        for (genvar i = 0; i < NUM_TMR; i++) begin : g_tmr
            dcmt_timer u_tmr (
                .mclk_in(mclk_in),
                .rst_n_in(rst_n_in),
                .load_in(tmr_load[i]),
                .load_val_in(tmr_val[i]),
                .busy_out(tmr_busy[i]),
                .last_out(tmr_last[i])
            );
        end
    endgenerate

    // Timer loads; each count is cycles minus one so the edge at the count is legal
    always_comb begin
        tmr_load[T_MRS] = (cmd_in.op == CMD_MRS);
        tmr_val[T_MRS] = 16'(MODE_SET_SPACING_CYC - 1);
        tmr_load[T_XP] = pd_exit;
        tmr_val[T_XP] = 16'(XP_CYC - 1);
        tmr_load[T_XPDLL] = pd_exit && mode_in.dll_frozen_pd;
        tmr_val[T_XPDLL] = 16'(XPDLL_CYC - 1);
        tmr_load[T_WRPD] = wr_go;
        tmr_val[T_WRPD] = (cmd_in.op == CMD_WRA) ? wr_recovery : wr_recovery - 16'h0001;
        // Auto-precharge finishes a row time after write recovery
        tmr_load[T_OPS] = (cmd_in.op == CMD_ACT) || (cmd_in.op == CMD_PRE) ||
                          (cmd_in.op == CMD_RDA) || (cmd_in.op == CMD_WRA) ||
                          (cmd_in.op == CMD_REF);
        tmr_val[T_OPS] = 16'(ROW_OP_CYC - 1);
        if (cmd_in.op == CMD_REF) begin
            tmr_val[T_OPS] = 16'(REFRESH_OP_CYC - 1);
        end else if (cmd_in.op == CMD_WRA) begin
            tmr_val[T_OPS] = wr_recovery + 16'(ROW_OP_CYC - 1);
        end
        tmr_load[T_ZQ] = (cmd_in.op == CMD_ZQCS);
        tmr_val[T_ZQ] = 16'(ZQCS_CYC - 1);
    end

    // Power state: entry waits until row, precharge and refresh work drains
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            PS_ACTIVE: begin
                if (cke_fall) begin
                    state_next = tmr_busy[T_OPS] ? PS_PENDING : PS_DOWN;
                end
            end
            PS_PENDING: begin
                if (cke_rise) begin
                    state_next = PS_ACTIVE;
                end else if (!tmr_busy[T_OPS]) begin
                    state_next = PS_DOWN;
                end
            end
            PS_DOWN: begin
                if (cke_rise) begin
                    state_next = PS_ACTIVE;
                end
            end
            default: begin
                state_next = PS_ACTIVE;
            end
        endcase
    end

    // Termination: async delay in frozen power down, write-latency based otherwise
    always_comb begin
        term_hist_next = {term_hist_reg[14:0], odt_in};
        if ((state_reg == PS_DOWN) && mode_in.dll_frozen_pd) begin
            term_next = term_hist_reg[ASYNC_TERM_CYC - 1];
        end else begin
            term_next = term_hist_reg[4'(mode_in.write_latency_cycles - TERM_LAT_INDEX_OFS)];
        end
    end

    // Write start pipe copes with overlapping writes at minimum spacing
    always_comb begin
        wpipe_next = wpipe_reg >> 1;
        if (wr_go) begin
            wpipe_next[5'(wdelay - 6'h01)] = 1'b1;
        end
    end

    // Termination high-time tracking, restarted by an eight-beat write
    always_comb begin
        term_cnt_next = term_cnt_reg;
        term_need_next = term_need_reg;
        if (odt_rise || (odt_in && wr_bl8)) begin
            term_cnt_next = 3'h1;
            term_need_next = wr_bl8 ? 3'(TERM_HIGH_LONG_CYC) : 3'(TERM_HIGH_SHORT_CYC);
        end else if (odt_in && (term_cnt_reg != 3'h7)) begin
            term_cnt_next = term_cnt_reg + 3'h1;
        end
    end

    // Refresh gap; no other upper bound on time between clocks
    always_comb begin
        gap_armed_next = gap_armed_reg || (cmd_in.op == CMD_REF);
        gap_cnt_next = gap_cnt_reg;
        if (cmd_in.op == CMD_REF) begin
            gap_cnt_next = TMR_RST;
        end else if (gap_armed_reg && (gap_cnt_reg != 16'hFFFF)) begin
            gap_cnt_next = gap_cnt_reg + 16'h0001;
        end
    end

    // Sticky breach flag; only a reset and reinitialization clears it
    always_comb begin
        viol_next = viol_reg;
        if (tmr_load[T_MRS] && tmr_busy[T_MRS]) begin
            viol_next = 1'b1;
        end
        if ((cmd_in.op != CMD_NOP) && tmr_busy[T_XP]) begin
            viol_next = 1'b1;
        end
        if (needs_locked_dll(cmd_in.op, odt_rise) && tmr_busy[T_XPDLL]) begin
            viol_next = 1'b1;
        end
        if (cke_fall && (tmr_busy[T_WRPD] || (cmd_in.op == CMD_REF))) begin
            viol_next = 1'b1;
        end
        if (odt_fall && (term_cnt_reg < term_need_reg)) begin
            viol_next = 1'b1;
        end
        if (gap_armed_reg && (gap_cnt_reg >= 16'(REFRESH_GAP_CYCLES)) &&
            (cmd_in.op != CMD_REF)) begin
            viol_next = 1'b1;
        end
    end

    // Register stage for all groups above except the timer bank, which counts inside dcmt_timer
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_reg <= PS_ACTIVE;
            cke_prev_reg <= 1'b0;
            odt_prev_reg <= 1'b0;
            term_hist_reg <= TERM_HIST_RST;
            term_reg <= 1'b0;
            wpipe_reg <= WPIPE_RST;
            term_cnt_reg <= TERM_CNT_RST;
            term_need_reg <= TERM_CNT_RST;
            gap_cnt_reg <= TMR_RST;
            gap_armed_reg <= 1'b0;
            zq_done_reg <= 1'b0;
            viol_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cke_prev_reg <= cke_in;
            odt_prev_reg <= odt_in;
            term_hist_reg <= term_hist_next;
            term_reg <= term_next;
            wpipe_reg <= wpipe_next;
            term_cnt_reg <= term_cnt_next;
            term_need_reg <= term_need_next;
            gap_cnt_reg <= gap_cnt_next;
            gap_armed_reg <= gap_armed_next;
            zq_done_reg <= tmr_last[T_ZQ];
            viol_reg <= viol_next;
        end
    end

    // Outputs
    assign write_start_out = wpipe_reg[0];
    assign low_power_out = (state_reg == PS_DOWN);
    assign term_on_out = term_reg;
    assign zq_busy_out = tmr_busy[T_ZQ];
    assign zq_done_out = zq_done_reg;
    assign violation_out = viol_reg;

    // Checks
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!rst_n_in);

    sequence s_mrs_early;
        (cmd_in.op == CMD_MRS) ##[1:3] (cmd_in.op == CMD_MRS);
    endsequence
    sequence s_term_short;
        (odt_rise && !wr_go) ##1 odt_in [*2] ##1 !odt_in;
    endsequence
    sequence s_term_long;
        (odt_in && wr_bl8) ##1 odt_in [*4] ##1 !odt_in;
    endsequence

    a_mrs_spacing:
    assert property (s_mrs_early |=> violation_out) else $error("early mode set missed");
    a_wstart_chop:
    assert property ((wr_go && mode_in.burst_mode == BM_BC4_FIXED &&
        mode_in.write_latency_cycles == 5'h05) |-> ##7 write_start_out)
        else $error("chop write start not at latency plus two");
    a_wstart_full:
    assert property ((wr_go && mode_in.burst_mode != BM_BC4_FIXED &&
        mode_in.write_latency_cycles == 5'h05) |-> ##9 write_start_out)
        else $error("write start not at latency plus four");
    a_zq_window:
    assert property (tmr_load[T_ZQ] && !zq_busy_out |=> zq_busy_out [*8] ##56 zq_done_out)
        else $error("calibration not done in 64 cycles");
    a_term_short_hold:
    assert property (s_term_short |=> violation_out) else $error("short termination missed");
    a_term_long_hold:
    assert property (s_term_long |=> violation_out) else $error("long termination missed");
    a_pd_waits_ops:
    assert property ($rose(low_power_out) |-> !$past(tmr_busy[T_OPS]))
        else $error("low power entered with operation running");
    a_exit_locked:
    assert property ((pd_exit && mode_in.dll_frozen_pd) ##[1:9] (cmd_in.op == CMD_RD)
        |=> violation_out) else $error("early locked command missed");
    a_viol_sticky:
    assert property (violation_out |=> violation_out) else $error("breach flag cleared");

endmodule

`default_nettype wire

// ### dv/dcmt_ctrl_model.sv
// Behavioural memory controller that puts commands on the device bus
`default_nettype none

module dcmt_ctrl_model
    import dcmt_pkg::*;
(
    // Clock
    input wire logic mclk_in,
    // Command bus towards the device
    output var dcmt_cmd_t cmd_out,
    output var logic cke_out,
    output var logic odt_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // Bus idles awake with no termination request
    initial begin
        cmd_out = '{op: CMD_NOP, otf_bc4: 1'b0};
        cke_out = 1'b1;
        odt_out = 1'b0;
    end

    // One bus cycle; changing at the falling edge gives each command one rising edge
    task automatic step(input dcmt_op_t op, input logic otf, input logic cke, input logic odt);
        @(negedge mclk_in);
        cmd_out = '{op: op, otf_bc4: otf};
        cke_out = cke;
        odt_out = odt;
    endtask

    // Idle cycles hold the present enable, termination and chop levels
    task automatic idle(input int n);
        repeat (n) step(CMD_NOP, cmd_out.otf_bc4, cke_out, odt_out);
    endtask
endmodule

`default_nettype wire

// ### dv/tb_top.sv
// Self-checking bench for the device-side command timing engine
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import dcmt_pkg::*;

    localparam int GAP = 40;
    localparam int LIMIT = 20000;

    logic mclk_in;
    logic rst_n_in;
    dcmt_mode_t mode;
    dcmt_cmd_t cmd;
    logic cke, odt, ws, lp, term, zqb, zqd, viol;
    int fail_count, samples_checked, seed, wl, wr, at, n;
    // Random chop bit; only an on-the-fly write reads it, so elsewhere it is free
    bit ro;
    int cycles = 0;
    int mrs_gap[3] = '{4, 3, 1};
    int bms[4] = '{0, 1, 1, 2};
    bit otfs[4] = '{0, 0, 1, 0};
    int oh_n[5] = '{3, 4, 5, 6, 4};
    int oh_w[5] = '{0, 0, 1, 1, 2};
    dcmt_op_t pe_op[6] = '{CMD_WR, CMD_WR, CMD_WRA, CMD_WRA, CMD_REF, CMD_REF};
    int pe_d[6] = '{-1, 0, -1, 0, -1, 0};
    dcmt_op_t px_op[5] = '{CMD_PRE, CMD_PRE, CMD_RD, CMD_RD, CMD_RDA};
    int px_k[5] = '{2, 3, 9, 10, 3};
    bit px_f[5] = '{0, 0, 1, 1, 0};

    // Controller model and the device engine, refresh gap shortened for run time
    dcmt_ctrl_model ctrl (.mclk_in(mclk_in), .cmd_out(cmd), .cke_out(cke), .odt_out(odt));
    dcmt_core #(.REFRESH_GAP_CYCLES(GAP)) dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
        .cmd_in(cmd), .cke_in(cke), .odt_in(odt), .mode_in(mode), .write_start_out(ws),
        .low_power_out(lp), .term_on_out(term), .zq_busy_out(zqb), .zq_done_out(zqd),
        .violation_out(viol));

    // 200 MHz clock
    initial begin
        mclk_in = 1'b0;
        forever #2.5 mclk_in = ~mclk_in;
    end

    // Hang guard: a run past the ceiling counts as a mismatch
    always @(posedge mclk_in) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            fail_count = fail_count + 1;
            close_out();
        end
    end

    task automatic close_out();
        if (fail_count == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %0d seen %0d", nm, exp, got);
        end
    endtask

    // Fresh latencies each time; the flag is sticky so every scenario starts from reset
    task automatic restart(input logic [1:0] bm, input logic frz);
        wl = 5 + $unsigned($random(seed)) % 12;
        wr = 5 + $unsigned($random(seed)) % 8;
        ro = 1'($unsigned($random(seed)) % 2);
        mode = '{write_latency_cycles: wl[4:0], wr_cycles: wr[3:0], burst_mode: bm,
            dll_frozen_pd: frz};
        rst_n_in = 1'b0;
        ctrl.step(CMD_NOP, ro, 1'b1, 1'b0);
        ctrl.idle(3);
        rst_n_in = 1'b1;
    endtask

    // Edges from the last driven edge to the first edge that samples the output high
    task automatic watch(input int sel, input int lim, output int res);
        logic [3:0] v;
        res = -1;
        for (int i = 0; i < lim && res < 0; i++) begin
            ctrl.idle(1);
            v = {term, lp, zqd, ws};
            if (v[sel] === 1'b1) res = i + 1;
        end
    endtask

    // Earliest legal clock-enable fall after a command
    function automatic int pd_gap(input dcmt_op_t op);
        case (op)
            CMD_WR: pd_gap = wl + WSTART_LONG_CYC + wr;
            CMD_WRA: pd_gap = wl + WSTART_LONG_CYC + wr + 1;
            default: pd_gap = 1;
        endcase
    endfunction

    // Main sequence, one table per group of timings except calibration, entry, termination delay and refresh
    initial begin
        seed = 19018;
        fail_count = 0;
        samples_checked = 0;
        rst_n_in = 1'b0;
        mode = '0;
        foreach (mrs_gap[k]) begin
            restart(2'h0, 1'b0);
            ctrl.step(CMD_MRS, ro, 1'b1, 1'b0);
            ctrl.idle(mrs_gap[k] - 1);
            ctrl.step(CMD_MRS, ro, 1'b1, 1'b0);
            ctrl.idle(2);
            chk("mode set spacing", mrs_gap[k] < MODE_SET_SPACING_CYC, viol);
        end
        foreach (bms[k]) begin
            restart(bms[k][1:0], 1'b0);
            // Shortest latency on one full and one chop write so the start checks fire
            if (k % 3 == 0) begin
                wl = 5;
                mode.write_latency_cycles = 5'h05;
            end
            ctrl.step(CMD_WR, otfs[k], 1'b1, 1'b0);
            watch(0, 30, at);
            chk("write start", wl + (bms[k] == 2 ? WSTART_SHORT_CYC : WSTART_LONG_CYC), at);
        end
        restart(2'h0, 1'b0);
        ctrl.step(CMD_ZQCS, ro, 1'b1, 1'b0);
        n = 0;
        at = -1;
        for (int i = 0; i < 70; i++) begin
            ctrl.idle(1);
            if (zqb === 1'b1) n++;
            if (zqd === 1'b1 && at < 0) at = i + 1;
        end
        chk("zq done", ZQCS_CYC, at);
        chk("zq busy", ZQCS_CYC - 1, n);
        // Power-down entry bare and behind a row activation, then exit
        for (int k = 0; k < 2; k++) begin
            restart(2'h0, 1'b0);
            if (k == 1) ctrl.step(CMD_ACT, ro, 1'b1, 1'b0);
            ctrl.step(CMD_NOP, ro, 1'b0, 1'b0);
            watch(2, 10, at);
            chk("power down entry", k == 1 ? ROW_OP_CYC : 1, at);
            ctrl.step(CMD_NOP, ro, 1'b1, 1'b0);
            ctrl.idle(2);
            chk("power down exit", 0, lp);
            chk("entry flag", 0, viol);
        end
        // Termination delay awake, then in frozen power down
        for (int k = 0; k < 2; k++) begin
            restart(2'h0, k[0]);
            if (k == 1) ctrl.step(CMD_NOP, ro, 1'b0, 1'b0);
            if (k == 1) ctrl.idle(4);
            ctrl.step(CMD_NOP, ro, cke, 1'b1);
            watch(3, 30, at);
            chk("termination delay", k == 1 ? 2 : wl - 1, at);
        end
        foreach (oh_n[k]) begin
            restart(oh_w[k] == 2 ? 2'h1 : 2'h0, 1'b0);
            ctrl.step(oh_w[k] > 0 ? CMD_WR : CMD_NOP, oh_w[k] == 2, 1'b1, 1'b1);
            ctrl.idle(oh_n[k] - 1);
            ctrl.step(CMD_NOP, ro, 1'b1, 1'b0);
            ctrl.idle(2);
            n = oh_w[k] == 1 ? TERM_HIGH_LONG_CYC : TERM_HIGH_SHORT_CYC;
            chk("termination high", oh_n[k] < n, viol);
        end
        foreach (pe_op[k]) begin
            restart(2'h0, 1'b0);
            n = pd_gap(pe_op[k]) + pe_d[k];
            ctrl.step(pe_op[k], ro, n > 0, 1'b0);
            ctrl.idle(n - 1);
            if (n > 0) ctrl.step(CMD_NOP, ro, 1'b0, 1'b0);
            ctrl.idle(2);
            chk("power down after command", pe_d[k] < 0, viol);
        end
        foreach (px_op[k]) begin
            restart(2'h0, px_f[k]);
            ctrl.step(CMD_NOP, ro, 1'b0, 1'b0);
            ctrl.idle(4);
            ctrl.step(CMD_NOP, ro, 1'b1, 1'b0);
            ctrl.idle(px_k[k] - 1);
            ctrl.step(px_op[k], ro, 1'b1, 1'b0);
            ctrl.idle(2);
            n = px_k[k] < XP_CYC || (px_f[k] && px_k[k] < XPDLL_CYC);
            chk("exit spacing", n, viol);
        end
        // Refresh gap at the limit, then overdue, then sticky
        restart(2'h0, 1'b0);
        ctrl.step(CMD_REF, ro, 1'b1, 1'b0);
        ctrl.idle(GAP - 1);
        ctrl.step(CMD_REF, ro, 1'b1, 1'b0);
        ctrl.idle(2);
        chk("refresh gap", 0, viol);
        ctrl.idle(GAP + 10);
        chk("refresh overdue", 1, viol);
        ctrl.step(CMD_REF, ro, 1'b1, 1'b0);
        ctrl.idle(2);
        chk("violation sticky", 1, viol);
        close_out();
    end
endmodule

`default_nettype wire
